// ===== include/smr_map.svh
// smr_map.svh: byte values, field positions and timing counts for the router
// assumes a 40 MHz system clock; included by bare name
`ifndef SMR_MAP_SVH
`define SMR_MAP_SVH
`define SMR_CLK_HZ        40000000
`define SMR_BAUD_MAX      115200
`define SMR_OVS           16
`define SMR_DIV_MAX       (`SMR_CLK_HZ / (`SMR_OVS * `SMR_BAUD_MAX))
`define SMR_DIV_DEF       16'h0015
`define SMR_SYNC_BYTE     8'hAA
`define SMR_DEVNUM_DEF    7'h0B
`define SMR_CMD_BIT       7
`define SMR_FRAME_BITS    10
`define SMR_FIFO_DEPTH    8
`endif

// ===== include/smr_pkg.sv
// smr_pkg.sv: shared types for the serial mode router
// assumes smr_map.svh is included where constants are needed
package smr_pkg;
  typedef enum logic [1:0] {
    SMR_DUAL,
    SMR_CHAIN,
    SMR_LINE
  } smr_mode_t;
endpackage

// ===== include/smr_if.sv
// smr_if.sv: serial line pair between router and far-end serial device
// assumes both ends share clk; the line itself is plain push-pull
`timescale 1ns/100ps
interface smr_if;
  logic dev_tx;  // router to partner
  logic dev_rx;  // partner to router
  modport dev (output dev_tx, input dev_rx);
  modport far (input dev_tx, output dev_rx);
endinterface

// ===== verilog/smr_fifo.sv
// smr_fifo.sv: small synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-low reset
`timescale 1ns/100ps
module smr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  // pointers wrap at power-of-two depth only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule // smr_fifo

// ===== verilog/smr_far.sv
// smr_far.sv: far-end serial device: 8-N-1 transmitter and receiver
// assumes the same clk as the router and a host-set baud divider
`timescale 1ns/100ps
`include "smr_map.svh"
module smr_far (
  input  wire logic        clk,
  input  wire logic        rst_n,
  smr_if.far               line,
  input  wire logic [15:0] baud_div,
  input  wire logic [7:0]  send_data,
  input  wire logic        send_valid,
  output logic             send_ready,
  output logic [7:0]       recv_data,
  output logic             recv_valid
);
  logic [15:0] tcnt;
  logic [3:0]  tbit;
  logic [9:0]  tsh;
  logic        tbusy;
  logic        s1;
  logic        s2;
  logic [15:0] rcnt;
  logic [3:0]  rbit;
  logic [7:0]  rsh;
  logic        rbusy;
  wire [15:0] bit_cyc = 16'(baud_div * `SMR_OVS);
  // a byte is taken on the edge where valid meets the registered ready
  wire        t_go    = send_valid && send_ready;
  // transmitter: start low, lsb first, stop high, idles high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbusy <= 1'b0;
      tsh <= 10'h3FF;
      tcnt <= '0;
      tbit <= '0;
      send_ready <= 1'b0;
      line.dev_rx <= 1'b1;
    end else begin
      send_ready <= !tbusy && !t_go;                  // drops once taken
      if (t_go) begin
        tsh <= {1'b1, send_data, 1'b0};
        tbusy <= 1'b1;
        tcnt <= '0;
        tbit <= '0;
      end else if (tbusy) begin
        line.dev_rx <= tsh[0];
        if (tcnt == bit_cyc - 16'h0001) begin
          tcnt <= '0;
          tsh <= {1'b1, tsh[9:1]};
          tbit <= tbit + 4'h1;
          if (tbit == 4'(`SMR_FRAME_BITS - 1)) tbusy <= 1'b0;
        end else tcnt <= tcnt + 16'h0001;
      end
    end
  end
  // receiver: samples at mid-bit after the start edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      rbusy <= 1'b0;
      rcnt <= '0;
      rbit <= '0;
      rsh <= '0;
      recv_data <= '0;
      recv_valid <= 1'b0;
    end else begin
      s1 <= line.dev_tx;
      s2 <= s1;
      recv_valid <= 1'b0;
      if (!rbusy) begin
        if (!s2) begin
          rbusy <= 1'b1;
          rcnt <= bit_cyc >> 1;
          rbit <= '0;
        end
      end else if (rcnt == bit_cyc - 16'h0001) begin
        rcnt <= '0;
        rbit <= rbit + 4'h1;
        if (rbit >= 4'h1 && rbit <= 4'h8) rsh <= {s2, rsh[7:1]};
        if (rbit == 4'h9) begin
          rbusy <= 1'b0;
          recv_data <= rsh;
          recv_valid <= s2;
        end
      end else rcnt <= rcnt + 16'h0001;
    end
  end
endmodule // smr_far

// ===== verilog/smr_router.sv
// smr_router.sv: serial mode router between two host channels, the
// rx/tx line and the command parser; 8-N-1 framing with auto-baud
// assumes host channels are byte streams with valid/ready on clk
// Function
// - rx bytes accepted only in serial input
// - dual mode: commands and replies on control
// - dual mode: bridge to tx, rx to bridge
// - dual mode baud comes from bridge channel
// - chained: control bytes to tx and parser
// - chained: replies only to control channel
// - chained: rx goes to control, not parser
// - chained baud from control; bridge idle
// - line mode: rx commands, tx replies, copy
// - line mode drops control writes; bridge unused
// - line mode fixed or 0xAA-detected baud
// - line mode only with serial input
// - frames are 8-N-1 both directions
// - idle high, start low, lsb first
// - stop bit high, ten bit times
// - up to 115200 baud back to back
// - sender sends 0xAA before commands
// - msb set marks command byte
// - packet is command plus its data
// - addressed packet: 0xAA, number, command
// - both packet forms, mismatched number ignored
`timescale 1ns/100ps
`include "smr_map.svh"
module smr_router #(
  parameter logic [15:0] FIXED_DIV = `SMR_DIV_DEF,
  parameter logic [6:0]  DEV_NUM   = `SMR_DEVNUM_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  smr_if.dev                    line,
  input  wire smr_pkg::smr_mode_t mode,
  input  wire logic             serial_input,
  input  wire logic             auto_baud,
  input  wire logic [15:0]      ctl_div,
  input  wire logic [15:0]      brg_div,
  input  wire logic [7:0]       ctl_in_data,
  input  wire logic             ctl_in_valid,
  output logic                  ctl_in_ready,
  output logic [7:0]            ctl_out_data,
  output logic                  ctl_out_valid,
  input  wire logic [7:0]       brg_in_data,
  input  wire logic             brg_in_valid,
  output logic                  brg_in_ready,
  output logic [7:0]            brg_out_data,
  output logic                  brg_out_valid,
  output logic [7:0]            par_data,
  output logic                  par_cmd,
  output logic                  par_valid,
  input  wire logic [7:0]       rsp_data,
  input  wire logic             rsp_valid,
  output logic                  rsp_ready,
  output logic                  baud_locked
);
  function automatic logic is_cmd(input logic [7:0] b);
    return b[`SMR_CMD_BIT];
  endfunction

  logic        s1, s2;
  logic [15:0] div_cnt;
  logic [15:0] det_div;
  logic [15:0] rcnt;
  logic [3:0]  rbit;
  logic [7:0]  rsh;
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic [3:0]  tph;
  logic [3:0]  tbit;
  logic [9:0]  tsh;
  logic        tbusy;
  logic [19:0] mcnt;
  logic        mrun;
  logic        addr_st;
  logic        addr_num;
  logic        drop_pkt;
  logic [7:0]  f_data;
  logic        f_valid;
  logic        f_ready;
  logic        f_ready_in;
  logic        sync_done;

  wire dual_m = (mode == smr_pkg::SMR_DUAL);
  wire chain_m = (mode == smr_pkg::SMR_CHAIN);
  wire line_m = (mode == smr_pkg::SMR_LINE) && serial_input;
  wire rx_en = serial_input;
  // baud source per mode
  wire [15:0] sel_div = dual_m ? brg_div :
                        chain_m ? ctl_div :
                        auto_baud ? det_div : FIXED_DIV;
  wire ovs_tick = (div_cnt == '0);
  // tx source per mode; responses never use tx in chained mode
  wire tx_src_v = dual_m ? brg_in_valid :
                  chain_m ? ctl_in_valid :
                  line_m ? f_valid : 1'b0;
  wire [7:0] tx_src_d = dual_m ? brg_in_data :
                        chain_m ? ctl_in_data : f_data;
  wire tx_take = tx_src_v && !tbusy;
  assign f_ready = line_m && !tbusy;
  // line mode discards control writes; dual sends them to the parser
  assign ctl_in_ready = chain_m ? !tbusy :
                        (dual_m || line_m || !serial_input);
  assign brg_in_ready = dual_m && !tbusy;
  wire resp_host = !line_m;
  // an rx copy owns the control channel that cycle; the reply waits
  wire rx_to_ctl = rx_stb && (chain_m || line_m);
  assign rsp_ready = resp_host ? !rx_to_ctl : f_ready_in;

  // response buffer toward tx in line mode; stalls the parser reply port
  smr_fifo #(.W(8), .D(`SMR_FIFO_DEPTH)) u_rsp_fifo (
    .clk(clk), .rst_n(rst_n),
    .in_data(rsp_data), .in_valid(rsp_valid && line_m),
    .in_ready(f_ready_in),
    .out_data(f_data), .out_valid(f_valid), .out_ready(f_ready));

  // oversample divider, reloads from the selected rate
  always_ff @(posedge clk) begin
    if (!rst_n) div_cnt <= '0;
    else if (ovs_tick) div_cnt <= sel_div - 16'h0001;
    else div_cnt <= div_cnt - 16'h0001;
  end

  // rx synchroniser and 16x receiver, sampling at phase 8
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 1'b1; s2 <= 1'b1;
      rcnt <= '0; rbit <= '0; rsh <= '0;
      rx_byte <= '0; rx_stb <= 1'b0;
    end else begin
      s1 <= line.dev_rx;
      s2 <= s1;
      rx_stb <= 1'b0;
      if (rbit == '0) begin
        if (rx_en && !s2 && ovs_tick) begin
          rbit <= 4'h1;
          rcnt <= '0;
        end
      end else if (ovs_tick) begin
        rcnt <= rcnt + 16'h0001;
        if (rcnt[3:0] == 4'h7) begin
          if (rbit == 4'h1 && s2) rbit <= '0;         // false start
          else if (rbit == 4'hA) begin
            rbit <= '0;
            rx_stb <= s2;
            rx_byte <= rsh;
          end else begin
            if (rbit >= 4'h2) rsh <= {s2, rsh[7:1]};
            rbit <= rbit + 4'h1;
          end
        end
      end
    end
  end

  // auto-baud: 0xAA sends start and a zero lsb, so its first low run is
  // two bits; a shorter run means a rate above the top baud and no lock
  wire run_ok = (mcnt >= 20'(2 * `SMR_OVS * `SMR_DIV_MAX - `SMR_OVS));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcnt <= '0; mrun <= 1'b0;
      det_div <= FIXED_DIV; baud_locked <= 1'b0;
    end else if (!(line_m && auto_baud)) begin
      baud_locked <= 1'b0;
      mrun <= 1'b0;
    end else if (!baud_locked) begin
      if (!mrun && !s2) begin
        mrun <= 1'b1; mcnt <= '0;
      end else if (mrun && !s2) mcnt <= mcnt + 20'h00001;
      else if (mrun && s2) begin
        mrun <= 1'b0;
        det_div <= 16'((mcnt + 20'h00010) >> 5);  // rounded, per 1/16 bit
        if (run_ok) baud_locked <= 1'b1;
      end
    end
  end

  // transmitter: ten-bit frame, back to back allowed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbusy <= 1'b0; tsh <= 10'h3FF; tph <= '0; tbit <= '0;
      line.dev_tx <= 1'b1;
    end else if (tx_take) begin
      tbusy <= 1'b1;
      tsh <= {1'b1, tx_src_d, 1'b0};
      tph <= '0; tbit <= '0;
    end else if (tbusy && ovs_tick) begin
      line.dev_tx <= tsh[0];
      tph <= tph + 4'h1;
      if (tph == 4'hF) begin
        tsh <= {1'b1, tsh[9:1]};
        tbit <= tbit + 4'h1;
        if (tbit == 4'(`SMR_FRAME_BITS - 1)) tbusy <= 1'b0;
      end
    end
  end

  // the sync character only sets the rate; parsing starts after it
  always_ff @(posedge clk) begin
    if (!rst_n || !(line_m && auto_baud && baud_locked)) sync_done <= 1'b0;
    else if (rx_stb) sync_done <= 1'b1;
  end

  // addressed-packet filter on parser-bound rx and control bytes
  wire rx_to_par = rx_stb && line_m && !(auto_baud && !sync_done);
  wire ctl_to_par = ctl_in_valid && ctl_in_ready && (dual_m || chain_m);
  wire [7:0] pin = rx_to_par ? rx_byte : ctl_in_data;
  wire pv = rx_to_par || ctl_to_par;
  wire sync_b = (pin == `SMR_SYNC_BYTE);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_st <= 1'b0; addr_num <= 1'b0; drop_pkt <= 1'b0;
      par_data <= '0; par_cmd <= 1'b0; par_valid <= 1'b0;
    end else begin
      par_valid <= 1'b0;
      if (pv) begin
        if (sync_b) begin
          addr_st <= 1'b1; drop_pkt <= 1'b0;
        end else if (addr_st) begin
          addr_st <= 1'b0;
          addr_num <= 1'b1;
          drop_pkt <= (pin[6:0] != DEV_NUM);
        end else if (addr_num) begin
          addr_num <= 1'b0;
          par_data <= {1'b1, pin[6:0]};
          par_cmd <= 1'b1;
          par_valid <= !drop_pkt;
        end else begin
          if (is_cmd(pin)) drop_pkt <= 1'b0;
          par_data <= pin;
          par_cmd <= is_cmd(pin);
          par_valid <= !(drop_pkt && !is_cmd(pin));
        end
      end
    end
  end

  // host-bound streams: rx copy and responses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_out_data <= '0; ctl_out_valid <= 1'b0;
      brg_out_data <= '0; brg_out_valid <= 1'b0;
    end else begin
      brg_out_valid <= rx_stb && dual_m;
      brg_out_data <= rx_byte;
      ctl_out_valid <= 1'b0;
      if (rx_stb && (chain_m || line_m)) begin
        ctl_out_valid <= 1'b1;
        ctl_out_data <= rx_byte;
      end else if (rsp_valid && resp_host) begin
        ctl_out_valid <= 1'b1;
        ctl_out_data <= rsp_data;
      end
    end
  end
endmodule // smr_router

// ===== sim/smr_checker.sv
// smr_checker.sv: run-length checks on both wires of the serial pair
// assumes one clock; every bit lasts BIT_MIN to BIT_MAX clocks
`timescale 1ns/100ps
module smr_checker #(
  parameter int BIT_MIN = 128,
  parameter int BIT_MAX = 336
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic dev_tx,
  input  wire logic dev_rx
);
  logic [15:0] tx_lo;
  logic [15:0] tx_hi;
  logic [15:0] rx_lo;
  logic [15:0] rx_hi;
  // high runs start saturated so the idle time after reset never looks short
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_lo <= 16'h0000;
      rx_lo <= 16'h0000;
      tx_hi <= 16'hFFFF;
      rx_hi <= 16'hFFFF;
    end else begin
      tx_lo <= dev_tx ? 16'h0000 : tx_lo + 16'h0001;
      rx_lo <= dev_rx ? 16'h0000 : rx_lo + 16'h0001;
      tx_hi <= !dev_tx ? 16'h0000 : (&tx_hi ? tx_hi : tx_hi + 16'h0001);
      rx_hi <= !dev_rx ? 16'h0000 : (&rx_hi ? rx_hi : rx_hi + 16'h0001);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a low run of a frame is one to nine whole bits, a high run at least one
  a_tx_idle_reset: assert property ($rose(rst_n) |-> dev_tx)
    else $error("tx not idle high after reset");
  a_rx_idle_reset: assert property ($rose(rst_n) |-> dev_rx)
    else $error("rx not idle high after reset");
  a_tx_low_min: assert property ($rose(dev_tx) |-> tx_lo >= BIT_MIN - 2)
    else $error("tx low run shorter than a bit");
  a_rx_low_min: assert property ($rose(dev_rx) |-> rx_lo >= BIT_MIN - 2)
    else $error("rx low run shorter than a bit");
  a_tx_low_max: assert property (!dev_tx |-> tx_lo < 9 * BIT_MAX + 4)
    else $error("tx low longer than start plus eight bits");
  a_rx_low_max: assert property (!dev_rx |-> rx_lo < 9 * BIT_MAX + 4)
    else $error("rx low longer than start plus eight bits");
  a_tx_stop_min: assert property ($fell(dev_tx) |-> tx_hi >= BIT_MIN - 2)
    else $error("tx stop or high run too short");
  a_rx_stop_min: assert property ($fell(dev_rx) |-> rx_hi >= BIT_MIN - 2)
    else $error("rx stop or high run too short");

  c_tx_frame: cover property ($rose(dev_tx));
  c_rx_frame: cover property ($rose(dev_rx));
  c_zero_byte: cover property ($rose(dev_tx) && tx_lo > 8 * BIT_MIN);
endmodule // smr_checker

// ===== sim/tb_serial_mode_router_uart.sv
// tb_serial_mode_router_uart.sv: router and far end joined by smr_if
// assumes smr_pkg and the design files are compiled before this file
`timescale 1ns/100ps
`include "smr_map.svh"
module tb_serial_mode_router_uart;
  logic               clk;
  logic               rst_n;
  smr_pkg::smr_mode_t mode;
  logic               serial_input;
  logic               auto_baud;
  logic [15:0]        ctl_div;
  logic [15:0]        brg_div;
  logic [15:0]        far_div;
  logic [3:0]         vld;
  logic [7:0]         dat [4];
  logic [7:0]         ctl_out_data, brg_out_data, par_data, recv_data;
  logic               ctl_in_ready, brg_in_ready, rsp_ready, send_ready;
  logic               ctl_out_valid, brg_out_valid, par_valid, recv_valid;
  logic               par_cmd, baud_locked;
  logic [8:0]         q_tx[$], q_ctl[$], q_brg[$], q_par[$];
  int                 fails, samples_checked;
  // channels: 0 control, 1 bridge, 2 responses, 3 far-end sender
  wire  [3:0]         rdy = {send_ready, rsp_ready, brg_in_ready, ctl_in_ready};

  smr_if i_smr_if ();
  smr_router i_smr_router (.clk(clk), .rst_n(rst_n), .line(i_smr_if),
    .mode(mode), .serial_input(serial_input), .auto_baud(auto_baud),
    .ctl_div(ctl_div), .brg_div(brg_div), .ctl_in_data(dat[0]),
    .ctl_in_valid(vld[0]), .ctl_in_ready(ctl_in_ready),
    .ctl_out_data(ctl_out_data), .ctl_out_valid(ctl_out_valid),
    .brg_in_data(dat[1]), .brg_in_valid(vld[1]), .brg_in_ready(brg_in_ready),
    .brg_out_data(brg_out_data), .brg_out_valid(brg_out_valid),
    .par_data(par_data), .par_cmd(par_cmd), .par_valid(par_valid),
    .rsp_data(dat[2]), .rsp_valid(vld[2]), .rsp_ready(rsp_ready),
    .baud_locked(baud_locked));
  smr_far i_smr_far (.clk(clk), .rst_n(rst_n), .line(i_smr_if),
    .baud_div(far_div), .send_data(dat[3]), .send_valid(vld[3]),
    .send_ready(send_ready), .recv_data(recv_data), .recv_valid(recv_valid));
  smr_checker i_smr_checker (.clk(clk), .rst_n(rst_n),
    .dev_tx(i_smr_if.dev_tx), .dev_rx(i_smr_if.dev_rx));

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic take(ref logic [8:0] q[$], input logic [8:0] got);
    if (q.size() == 0) begin
      samples_checked++;
      fails++;
      $display("BAD %0t unexpected byte %h", $time, got);
    end else begin
      check(got, q.pop_front());
    end
  endtask

  // request held from one edge until the edge where its ready is seen
  task automatic push(input int ch, input logic [7:0] d);
    int n;
    n = 0;
    dat[ch] <= d;
    vld[ch] <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy[ch] !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      fails++;
      $display("BAD %0t channel %0d never ready", $time, ch);
    end
    vld[ch] <= 1'b0;
    @(posedge clk);
  endtask

  // note where the byte must come out (tx, ctl, bridge, parser), then send
  task automatic xfer(input int ch, input logic [7:0] d, input logic [3:0] to);
    if (to[0]) q_tx.push_back({1'b0, d});
    if (to[1]) q_ctl.push_back({1'b0, d});
    if (to[2]) q_brg.push_back({1'b0, d});
    if (to[3]) q_par.push_back({d[7], d});
    push(ch, d);
  endtask

  // fixed wait of n clock cycles, then nothing may be left outstanding
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    check(9'(q_tx.size() + q_ctl.size() + q_brg.size() + q_par.size()), 9'h0);
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // each result pulse is matched against the oldest note of its kind
  always @(posedge clk) begin
    if (recv_valid === 1'b1) take(q_tx, {1'b0, recv_data});
    if (ctl_out_valid === 1'b1) take(q_ctl, {1'b0, ctl_out_data});
    if (brg_out_valid === 1'b1) take(q_brg, {1'b0, brg_out_data});
    if (par_valid === 1'b1) take(q_par, {par_cmd, par_data});
  end

  // hang guard: whole run is about 55k cycles
  initial begin
    repeat (99000) @(posedge clk);
    fails++;
    $display("BAD %0t run did not finish", $time);
    summarize();
  end

  initial begin
    int k;
    rst_n = 1'b0;
    mode = smr_pkg::SMR_DUAL;
    serial_input = 1'b1;
    auto_baud = 1'b0;
    ctl_div = 16'h0063;
    brg_div = 16'h0008;
    far_div = 16'h0008;
    vld = 4'h0;
    for (int i = 0; i < 4; i++) dat[i] = 8'h00;
    k = $urandom(32'hBDE0);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // dual: bridge at the bridge rate both ways, control to the parser
    fork
      for (int i = 0; i < 3; i++) xfer(1, 8'($urandom), 4'h1);
      for (int i = 0; i < 2; i++) xfer(3, 8'($urandom), 4'h4);
    join
    // addressed packets: own number passes, another number is dropped
    xfer(0, `SMR_SYNC_BYTE, 4'h0);
    xfer(0, {1'b0, `SMR_DEVNUM_DEF}, 4'h0);
    q_par.push_back(9'h1E1);
    xfer(0, 8'h61, 4'h0);
    xfer(0, 8'h7F, 4'h8);
    xfer(0, `SMR_SYNC_BYTE, 4'h0);
    xfer(0, 8'h05, 4'h0);
    xfer(0, 8'h61, 4'h0);
    xfer(0, 8'h7F, 4'h0);
    // bit 6 set keeps random commands off the sync value
    xfer(0, 8'hC0 | 8'($urandom), 4'h8);
    xfer(0, 8'h7F & 8'($urandom), 4'h8);
    xfer(2, 8'($urandom), 4'h2);
    idle(1500);
    $display("test dual done");
    // chained: control bytes go out and to the parser, replies stay local
    mode <= smr_pkg::SMR_CHAIN;
    ctl_div <= 16'h0008;
    brg_div <= 16'h0063;
    xfer(0, 8'h00, 4'h9);
    xfer(0, 8'hC0 | 8'($urandom), 4'h9);
    xfer(2, 8'($urandom), 4'h2);
    xfer(3, 8'h80 | 8'($urandom), 4'h2);
    check({8'h00, rdy[1]}, 9'h000);
    idle(1500);
    $display("test chained done");
    // rx is ignored when serial input is off
    serial_input <= 1'b0;
    xfer(3, 8'h55, 4'h0);
    idle(1500);
    $display("test rx off done");
    // line mode: detect the rate from the sync byte, then parse from rx
    mode <= smr_pkg::SMR_LINE;
    serial_input <= 1'b1;
    auto_baud <= 1'b1;
    far_div <= `SMR_DIV_DEF;
    xfer(3, `SMR_SYNC_BYTE, 4'h2);
    idle(3800);
    check({8'h00, baud_locked}, 9'h001);
    xfer(0, 8'h85, 4'h0);
    xfer(3, 8'h85, 4'hA);
    idle(3800);
    // stuff replies until the buffer refuses; all accepted go out on tx
    k = 0;
    do begin
      dat[2] <= 8'h30 + 8'(k);
      vld[2] <= 1'b1;
      @(posedge clk);
      if (rsp_ready === 1'b1) q_tx.push_back({1'b0, 8'h30 + 8'(k)});
      k++;
    end while (rsp_ready === 1'b1 && k < 16);
    // fifo words plus the one in the transmitter, then one refusal
    check(9'(k), 9'(`SMR_FIFO_DEPTH + 2));
    // the refused reply stays offered until the buffer has room again
    q_tx.push_back({1'b0, 8'h30 + 8'(k - 1)});
    push(2, 8'h30 + 8'(k - 1));
    idle(36000);
    $display("test line done");
    summarize();
  end
endmodule // tb_serial_mode_router_uart
